// ---- pacr_pkg.sv ----
// pacr_pkg: constants, register map and types of the front-end configuration bank
// assumes: compiled before every other file of the block
package pacr_pkg;

    localparam int REG_W      = 16;
    localparam int ADDR_W     = 3;
    localparam int NUM_REGS   = 6;
    localparam int CNT_W      = 5;
    // address bits then data bits, both lsb first
    localparam int FRAME_BITS = 19;

    localparam logic [2:0] ADDR_POWER  = 3'h0;
    localparam logic [2:0] ADDR_RXFILT = 3'h1;
    localparam logic [2:0] ADDR_GAIN   = 3'h2;
    localparam logic [2:0] ADDR_RSVD_A = 3'h3;
    localparam logic [2:0] ADDR_RSVD_B = 3'h4;
    localparam logic [2:0] ADDR_DRIVER = 3'h5;

    localparam int PWR_RX_IN_TX   = 0;
    localparam int PWR_TX_IN_RX   = 1;
    localparam int PWR_DAC_IN_RX  = 2;
    localparam int PWR_FULL       = 3;
    localparam int RXF_LPF_BYPASS = 15;
    localparam int PGT_GAIN_LSB   = 2;
    localparam int PGT_GAIN_MSB   = 4;
    localparam int PGT_TUNE       = 11;
    localparam int DRV_LD_LSB     = 1;
    localparam int DRV_LD_MSB     = 2;
    localparam int DRV_TX_LPF     = 4;
    localparam int DRV_RX_HPF     = 14;

    localparam logic [1:0] LD_INTERNAL  = 2'h0;
    localparam logic [1:0] LD_BYPASS_1K = 2'h1;
    localparam logic [1:0] LD_UNDEFINED = 2'h2;
    localparam logic [1:0] LD_BYPASS_50 = 2'h3;

    localparam logic [REG_W-1:0] REG_DEFAULT [NUM_REGS] = '{
        16'h0003, 16'h0008, 16'h7800, 16'h7ace, 16'h0000, 16'hc800};

    // gain in dB for codes 0..7
    localparam logic signed [3:0] GAIN_DB [8] = '{
        4'sh3, 4'sh2, 4'sh1, 4'sh0, 4'shf, 4'she, 4'shd, 4'sha};

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SHIFT = 3'h1,
        ST_XFER  = 3'h3,
        ST_ARMED = 3'h2,
        ST_READ  = 3'h6
    } pacr_state_t;

    // data above address, so the frame maps straight onto the shifter
    typedef struct packed {
        logic [REG_W-1:0]  data;
        logic [ADDR_W-1:0] addr;
    } pacr_frame_t;

    typedef struct packed {
        logic              rx_path_off;
        logic              tx_path_off;
        logic              dac_off;
        logic              device_off;
        logic              rx_lowpass_bypass;
        logic [2:0]        predriver_gain;
        logic signed [3:0] gain_db;
        logic              process_tune_run;
        logic              line_driver_bypass;
        logic              line_driver_high_current;
        logic              tx_lowpass_bypass;
        logic              rx_highpass_enable;
    } pacr_ctrl_t;

endpackage

// ---- pacr_serial_port.sv ----
// pacr_serial_port: three-wire serial port, runs on falling edges of the serial clock
// assumes: the controller keeps the serial clock running while sys_rst is high
`timescale 1ns/10ps
`default_nettype none
module pacr_serial_port
(
    input  wire logic                  sys_rst,
    input  wire logic                  sclk_link,
    input  wire logic                  write_read_select,
    input  wire logic                  sdio_in,
    output logic                       sdio_out,
    output logic                       sdio_oe_n,
    output var pacr_pkg::pacr_frame_t  hold_frame,
    output logic                       wr_tgl
);
    import pacr_pkg::*;

    logic              rst_meta_reg;
    logic              rst_sync_reg;
    logic              swr_prev_reg;
    logic              swr_prev_next;
    pacr_state_t       state_reg;
    pacr_state_t       state_next;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    logic [FRAME_BITS-1:0] shift_reg;
    logic [FRAME_BITS-1:0] shift_next;
    logic [REG_W-1:0]  rd_reg;
    logic [REG_W-1:0]  rd_next;
    pacr_frame_t       hold_reg;
    pacr_frame_t       hold_next;
    logic              tgl_reg;
    logic              tgl_next;
    logic              out_reg;
    logic              out_next;
    logic              oe_n_reg;
    logic              oe_n_next;

    always_comb
    begin
        swr_prev_next = write_read_select;
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        shift_next    = shift_reg;
        rd_next       = rd_reg;
        hold_next     = hold_reg;
        tgl_next      = tgl_reg;
        out_next      = out_reg;
        oe_n_next     = 1'b1;
        if (rst_sync_reg)
        begin
            swr_prev_next = 1'b0;
            state_next    = ST_IDLE;
            cnt_next      = '0;
            shift_next    = '0;
            rd_next       = '0;
            hold_next     = '0;
            tgl_next      = 1'b0;
            out_next      = 1'b0;
        end
        else if (write_read_select && !swr_prev_reg)
        begin
            // a rising select restarts the frame whatever came before
            shift_next = {sdio_in, shift_reg[FRAME_BITS-1:1]};
            cnt_next   = CNT_W'(1);
            state_next = ST_SHIFT;
        end
        else
        begin
            case (state_reg)
                ST_SHIFT:
                begin
                    if (write_read_select)
                    begin
                        shift_next = {sdio_in, shift_reg[FRAME_BITS-1:1]};
                        cnt_next   = cnt_reg + CNT_W'(1);
                        if (cnt_reg == CNT_W'(FRAME_BITS - 1))
                            state_next = ST_XFER;
                    end
                    else
                        state_next = ST_IDLE;
                end
                ST_XFER:
                begin
                    if (write_read_select)
                    begin
                        // extra clock moves the holding buffer to the bank
                        hold_next = pacr_frame_t'(shift_reg);
                        if (shift_reg[ADDR_W-1:0] < ADDR_W'(NUM_REGS))
                        begin
                            tgl_next   = ~tgl_reg;
                            state_next = ST_ARMED;
                        end
                        else
                            state_next = ST_IDLE;
                    end
                    else
                        state_next = ST_IDLE;
                end
                ST_ARMED:
                begin
                    // readback is the word just committed, equal to the register
                    if (!write_read_select)
                    begin
                        out_next   = hold_reg.data[0];
                        oe_n_next  = 1'b0;
                        rd_next    = {1'b0, hold_reg.data[REG_W-1:1]};
                        cnt_next   = CNT_W'(1);
                        state_next = ST_READ;
                    end
                end
                ST_READ:
                begin
                    if (!write_read_select && cnt_reg != CNT_W'(REG_W))
                    begin
                        out_next  = rd_reg[0];
                        oe_n_next = 1'b0;
                        rd_next   = {1'b0, rd_reg[REG_W-1:1]};
                        cnt_next  = cnt_reg + CNT_W'(1);
                    end
                    else
                        state_next = ST_IDLE;
                end
                default:
                    state_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(negedge sclk_link)
    begin
        rst_meta_reg <= sys_rst;
        rst_sync_reg <= rst_meta_reg;
        swr_prev_reg <= swr_prev_next;
        state_reg    <= state_next;
        cnt_reg      <= cnt_next;
        shift_reg    <= shift_next;
        rd_reg       <= rd_next;
        hold_reg     <= hold_next;
        tgl_reg      <= tgl_next;
        out_reg      <= out_next;
        oe_n_reg     <= oe_n_next;
    end

    assign sdio_out   = out_reg;
    assign sdio_oe_n  = oe_n_reg;
    assign hold_frame = hold_reg;
    assign wr_tgl     = tgl_reg;

    property p_shift_in;
        @(negedge sclk_link) disable iff (rst_sync_reg)
        write_read_select && (!swr_prev_reg || state_reg == ST_SHIFT)
            |=> shift_reg[FRAME_BITS-1] == $past(sdio_in);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("serial bit not sampled");

    property p_frame_len;
        @(negedge sclk_link) disable iff (rst_sync_reg)
        (state_reg == ST_SHIFT && swr_prev_reg && write_read_select && cnt_reg == CNT_W'(FRAME_BITS - 1))
            |=> state_reg == ST_XFER;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

    property p_commit;
        @(negedge sclk_link) disable iff (rst_sync_reg)
        (state_reg == ST_XFER && swr_prev_reg && write_read_select && shift_reg[ADDR_W-1:0] < ADDR_W'(NUM_REGS))
            |=> (tgl_reg != $past(tgl_reg)) && hold_reg == $past(shift_reg);
    endproperty
    a_commit: assert property (p_commit) else $error("extra clock did not commit");

    sequence s_read_start;
        state_reg == ST_ARMED && !write_read_select;
    endsequence
    sequence s_read_two;
        !oe_n_reg && out_reg == hold_reg.data[0] ##1 !oe_n_reg && out_reg == hold_reg.data[1];
    endsequence
    property p_read;
        @(negedge sclk_link) disable iff (rst_sync_reg)
        s_read_start ##1 !write_read_select |-> s_read_two;
    endproperty
    a_read: assert property (p_read) else $error("readback bits wrong");

endmodule
`default_nettype wire

// ---- pacr_config_regs.sv ----
// pacr_config_regs: six-word configuration bank of the powerline front end
// assumes: serial port pins come from the baseband controller on their own clock;
// tx_enable is an asynchronous pin; sys_rst is synchronous to ref_clk
// Function
// - addresses 0 to 5 pick six read/write 16-bit registers
// - power bit 0 shuts the receive path while transmitting, default one
// - power bit 1 shuts the transmit path while receiving, default one
// - power bit 2 shuts the dac while receiving, default zero
// - power bit 3 shuts the whole device; bits 4 to 15 reserved zero
// - receive-filter bit 15 bypasses the receive lowpass; only bit 3 defaults one
// - gain register bits 4:2 pick predriver gain +3 down to -6 dB
// - gain register bit 11 runs process tuning always, else only in reset
// - driver bits 2:1 select internal driver or one of two bypass modes
// - driver bit 4 allows the transmit lowpass bypass, default zero
// - driver bit 14 disables the receive highpass, default one
// - select high means write; bits enter lsb first on falling clock
// - one extra serial clock after the data commits the holding buffer
`timescale 1ns/10ps
`default_nettype none
module pacr_config_regs
(
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic                sclk_link,
    input  wire logic                write_read_select,
    input  wire logic                sdio_in,
    output logic                     sdio_out,
    output logic                     sdio_oe_n,
    input  wire logic                tx_enable,
    output var pacr_pkg::pacr_ctrl_t afe_ctrl
);
    import pacr_pkg::*;

    pacr_frame_t      frame;
    logic             wr_tgl;
    logic             tgl_meta_reg;
    logic             tgl_meta_next;
    logic             tgl_sync_reg;
    logic             tgl_sync_next;
    logic             tgl_seen_reg;
    logic             tgl_seen_next;
    logic             tx_meta_reg;
    logic             tx_meta_next;
    logic             tx_sync_reg;
    logic             tx_sync_next;
    logic             write_evt;
    logic [REG_W-1:0] bank_reg [NUM_REGS];
    logic [REG_W-1:0] bank_next [NUM_REGS];
    pacr_ctrl_t       ctrl_reg;
    pacr_ctrl_t       ctrl_next;
    logic [REG_W-1:0] pwr;
    logic [REG_W-1:0] rxf;
    logic [REG_W-1:0] pgt;
    logic [REG_W-1:0] drv;
    logic             tx_mode;

    pacr_serial_port u_port
    (
        .sys_rst           (sys_rst),
        .sclk_link         (sclk_link),
        .write_read_select (write_read_select),
        .sdio_in           (sdio_in),
        .sdio_out          (sdio_out),
        .sdio_oe_n         (sdio_oe_n),
        .hold_frame        (frame),
        .wr_tgl            (wr_tgl)
    );

    // toggle crossing: the frame word is frozen until the next frame, far later
    always_comb
    begin
        tgl_meta_next = wr_tgl;
        tgl_sync_next = tgl_meta_reg;
        tgl_seen_next = tgl_sync_reg;
        tx_meta_next  = tx_enable;
        tx_sync_next  = tx_meta_reg;
        if (sys_rst)
        begin
            tgl_meta_next = 1'b0;
            tgl_sync_next = 1'b0;
            tgl_seen_next = 1'b0;
            tx_meta_next  = 1'b0;
            tx_sync_next  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        tgl_meta_reg <= tgl_meta_next;
        tgl_sync_reg <= tgl_sync_next;
        tgl_seen_reg <= tgl_seen_next;
        tx_meta_reg  <= tx_meta_next;
        tx_sync_reg  <= tx_sync_next;
    end

    assign write_evt = tgl_sync_reg ^ tgl_seen_reg;

    // reserved bits store whatever is written; the controller keeps defaults
    always_comb
    begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
            bank_next[i] = bank_reg[i];
            if (sys_rst)
                bank_next[i] = REG_DEFAULT[i];
            else if (write_evt && frame.addr == ADDR_W'(i))
                bank_next[i] = frame.data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < NUM_REGS; i++)
            bank_reg[i] <= bank_next[i];
    end

    // controls follow the bank in the same cycle it updates
    always_comb
    begin
        pwr     = bank_next[ADDR_POWER];
        rxf     = bank_next[ADDR_RXFILT];
        pgt     = bank_next[ADDR_GAIN];
        drv     = bank_next[ADDR_DRIVER];
        // second flop only, the first may still be settling
        tx_mode = tx_sync_reg & ~sys_rst;
        ctrl_next = '0;
        ctrl_next.device_off  = pwr[PWR_FULL];
        ctrl_next.rx_path_off = pwr[PWR_FULL] | (pwr[PWR_RX_IN_TX] & tx_mode);
        ctrl_next.tx_path_off = pwr[PWR_FULL] | (pwr[PWR_TX_IN_RX] & ~tx_mode);
        ctrl_next.dac_off     = pwr[PWR_FULL] | (pwr[PWR_DAC_IN_RX] & ~tx_mode);
        ctrl_next.rx_lowpass_bypass = rxf[RXF_LPF_BYPASS];
        ctrl_next.predriver_gain    = pgt[PGT_GAIN_MSB:PGT_GAIN_LSB];
        ctrl_next.gain_db           = GAIN_DB[pgt[PGT_GAIN_MSB:PGT_GAIN_LSB]];
        // tuning always runs while reset is held
        ctrl_next.process_tune_run  = pgt[PGT_TUNE] | sys_rst;
        case (drv[DRV_LD_MSB:DRV_LD_LSB])
            LD_BYPASS_1K:
            begin
                ctrl_next.line_driver_bypass       = 1'b1;
                ctrl_next.line_driver_high_current = 1'b0;
            end
            LD_BYPASS_50:
            begin
                ctrl_next.line_driver_bypass       = 1'b1;
                ctrl_next.line_driver_high_current = 1'b1;
            end
            default:
            begin
                // the undefined code keeps the internal driver, the safe choice
                ctrl_next.line_driver_bypass       = 1'b0;
                ctrl_next.line_driver_high_current = 1'b0;
            end
        endcase
        ctrl_next.tx_lowpass_bypass  = drv[DRV_TX_LPF];
        ctrl_next.rx_highpass_enable = ~drv[DRV_RX_HPF];
    end

    always_ff @(posedge ref_clk)
    begin
        ctrl_reg <= ctrl_next;
    end

    assign afe_ctrl = ctrl_reg;

    property p_reset_defaults;
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> bank_reg[ADDR_POWER] == REG_DEFAULT[0] && bank_reg[ADDR_RXFILT] == REG_DEFAULT[1]
            && bank_reg[ADDR_GAIN] == REG_DEFAULT[2] && bank_reg[ADDR_RSVD_A] == REG_DEFAULT[3]
            && bank_reg[ADDR_RSVD_B] == REG_DEFAULT[4] && bank_reg[ADDR_DRIVER] == REG_DEFAULT[5];
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bank not at defaults");

    property p_write_lands;
        @(posedge ref_clk) disable iff (sys_rst)
        write_evt |=> bank_reg[$past(frame.addr)] == $past(frame.data) && !write_evt;
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write did not land");

    property p_cross_delay;
        @(posedge ref_clk) disable iff (sys_rst)
        $changed(wr_tgl) |-> ##[2:3] write_evt;
    endproperty
    a_cross_delay: assert property (p_cross_delay) else $error("commit lost in crossing");

    property p_rx_pd;
        @(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && tx_enable && bank_reg[ADDR_POWER][PWR_RX_IN_TX])[*4] |-> afe_ctrl.rx_path_off;
    endproperty
    a_rx_pd: assert property (p_rx_pd) else $error("receiver on during transmit");

    property p_tx_pd;
        @(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && !tx_enable && bank_reg[ADDR_POWER][PWR_TX_IN_RX])[*4] |-> afe_ctrl.tx_path_off;
    endproperty
    a_tx_pd: assert property (p_tx_pd) else $error("transmitter on during receive");

    property p_dac_pd;
        @(posedge ref_clk) disable iff (sys_rst)
        (!sys_rst && !tx_enable)[*4] ##0 !bank_reg[ADDR_POWER][PWR_FULL]
            |-> afe_ctrl.dac_off == bank_reg[ADDR_POWER][PWR_DAC_IN_RX];
    endproperty
    a_dac_pd: assert property (p_dac_pd) else $error("dac power state wrong");

    property p_full_pd;
        @(posedge ref_clk) disable iff (sys_rst)
        bank_reg[ADDR_POWER][PWR_FULL] |-> afe_ctrl.device_off && afe_ctrl.rx_path_off
            && afe_ctrl.tx_path_off && afe_ctrl.dac_off;
    endproperty
    a_full_pd: assert property (p_full_pd) else $error("full power-down incomplete");

    property p_rx_lpf;
        @(posedge ref_clk) disable iff (sys_rst)
        write_evt && frame.addr == ADDR_RXFILT |=> afe_ctrl.rx_lowpass_bypass == $past(frame.data[RXF_LPF_BYPASS]);
    endproperty
    a_rx_lpf: assert property (p_rx_lpf) else $error("receive lowpass bypass wrong");

    property p_gain;
        @(posedge ref_clk) disable iff (sys_rst)
        bank_reg[ADDR_GAIN][PGT_GAIN_MSB:PGT_GAIN_LSB] == 3'h7 |-> afe_ctrl.gain_db == -4'sd6;
    endproperty
    a_gain: assert property (p_gain) else $error("lowest gain code not -6 dB");

    property p_tune;
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> afe_ctrl.process_tune_run ##1 afe_ctrl.process_tune_run == bank_reg[ADDR_GAIN][PGT_TUNE];
    endproperty
    a_tune: assert property (p_tune) else $error("process tune mode wrong");

    property p_line_driver;
        @(posedge ref_clk) disable iff (sys_rst)
        bank_reg[ADDR_DRIVER][DRV_LD_MSB:DRV_LD_LSB] == LD_UNDEFINED |-> !afe_ctrl.line_driver_bypass;
    endproperty
    a_line_driver: assert property (p_line_driver) else $error("undefined driver code bypassed");

    property p_tx_lpf;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(bank_reg[ADDR_DRIVER][DRV_TX_LPF]) |-> $rose(afe_ctrl.tx_lowpass_bypass);
    endproperty
    a_tx_lpf: assert property (p_tx_lpf) else $error("transmit lowpass bypass late");

    property p_rx_hpf;
        @(posedge ref_clk) disable iff (sys_rst)
        write_evt && frame.addr == ADDR_DRIVER |=> afe_ctrl.rx_highpass_enable != $past(frame.data[DRV_RX_HPF]);
    endproperty
    a_rx_hpf: assert property (p_rx_hpf) else $error("receive highpass state wrong");

    property p_ld_1k;
        @(posedge ref_clk) disable iff (sys_rst)
        bank_reg[ADDR_DRIVER][DRV_LD_MSB:DRV_LD_LSB] == LD_BYPASS_1K
            |-> afe_ctrl.line_driver_bypass && !afe_ctrl.line_driver_high_current;
    endproperty
    a_ld_1k: assert property (p_ld_1k) else $error("1k bypass wrong");

    property p_ld_50;
        @(posedge ref_clk) disable iff (sys_rst)
        bank_reg[ADDR_DRIVER][DRV_LD_MSB:DRV_LD_LSB] == LD_BYPASS_50
            |-> afe_ctrl.line_driver_bypass && afe_ctrl.line_driver_high_current;
    endproperty
    a_ld_50: assert property (p_ld_50) else $error("50 ohm bypass wrong");

    property p_ld_int;
        @(posedge ref_clk) disable iff (sys_rst)
        bank_reg[ADDR_DRIVER][DRV_LD_MSB:DRV_LD_LSB] == LD_INTERNAL
            |-> !afe_ctrl.line_driver_bypass && !afe_ctrl.line_driver_high_current;
    endproperty
    a_ld_int: assert property (p_ld_int) else $error("internal driver not kept");

    property p_gain_code;
        @(posedge ref_clk) disable iff (sys_rst)
        afe_ctrl.predriver_gain == bank_reg[ADDR_GAIN][PGT_GAIN_MSB:PGT_GAIN_LSB];
    endproperty
    a_gain_code: assert property (p_gain_code) else $error("gain code wrong");

    property p_gain_top;
        @(posedge ref_clk) disable iff (sys_rst)
        bank_reg[ADDR_GAIN][PGT_GAIN_MSB:PGT_GAIN_LSB] == 3'h0 |-> afe_ctrl.gain_db == 4'sh3;
    endproperty
    a_gain_top: assert property (p_gain_top) else $error("top gain code not +3 dB");

    property p_tune_lvl;
        @(posedge ref_clk) disable iff (sys_rst)
        afe_ctrl.process_tune_run == bank_reg[ADDR_GAIN][PGT_TUNE];
    endproperty
    a_tune_lvl: assert property (p_tune_lvl) else $error("tune mode not following bit");

    property p_dev_off_lvl;
        @(posedge ref_clk) disable iff (sys_rst)
        afe_ctrl.device_off == bank_reg[ADDR_POWER][PWR_FULL];
    endproperty
    a_dev_off_lvl: assert property (p_dev_off_lvl) else $error("device off not following bit");

    property p_rx_lpf_lvl;
        @(posedge ref_clk) disable iff (sys_rst)
        afe_ctrl.rx_lowpass_bypass == bank_reg[ADDR_RXFILT][RXF_LPF_BYPASS];
    endproperty
    a_rx_lpf_lvl: assert property (p_rx_lpf_lvl) else $error("receive lowpass level wrong");

    property p_rx_hpf_lvl;
        @(posedge ref_clk) disable iff (sys_rst)
        afe_ctrl.rx_highpass_enable != bank_reg[ADDR_DRIVER][DRV_RX_HPF];
    endproperty
    a_rx_hpf_lvl: assert property (p_rx_hpf_lvl) else $error("receive highpass level wrong");

endmodule
`default_nettype wire

// ---- pacr_ctl_model.sv ----
// pacr_ctl_model: baseband controller side of the three-wire serial port
// assumes: serial clock stands still between calls; tasks are called from the bench
`timescale 1ns/10ps
`default_nettype none
module pacr_ctl_model
(
    output logic      sclk_link,
    output logic      write_read_select,
    output logic      sdio_in,
    input  wire logic sdio_out,
    input  wire logic sdio_oe_n
);
    initial
    begin
        sclk_link         = 1'b0;
        write_read_select = 1'b0;
        sdio_in           = 1'b0;
    end

    // one 30 ns serial clock; the fall sits off the system clock edges
    task automatic tick();
        sclk_link = 1'b1;
        #16;
        sclk_link = 1'b0;
        #14;
    endtask

    task automatic send(input logic [2:0] a, input logic [15:0] d, input logic extra);
        logic [18:0] f;
        f = {d, a};
        write_read_select = 1'b0;
        tick();
        for (int i = 0; i < 19; i++)
        begin
            write_read_select = 1'b1;
            sdio_in = f[i];
            tick();
        end
        // released line shows no stale value
        sdio_in = ~sdio_in;
        if (extra)
            tick();
    endtask

    task automatic fetch(output logic [15:0] d, output logic oe);
        oe = 1'b0;
        write_read_select = 1'b0;
        for (int k = 0; k < 16; k++)
        begin
            tick();
            // a released pin reads as the inverse, so a missing drive shows
            d[k] = sdio_oe_n ? ~sdio_out : sdio_out;
            oe = oe | ~sdio_oe_n;
        end
        tick();
    endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// testbench: table driven check of the configuration bank through its serial port
// assumes: pacr_pkg, pacr_config_regs and pacr_ctl_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import pacr_pkg::*;
    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] data;
        logic        tx;
    } pacr_row_t;

    logic       ref_clk;
    logic       sys_rst;
    logic       tx_enable;
    wire logic  sclk_link;
    wire logic  write_read_select;
    wire logic  sdio_in;
    wire logic  sdio_out;
    wire logic  sdio_oe_n;
    pacr_ctrl_t afe_ctrl;
    int         err_count;
    int         check_count;
    logic [15:0] shadow [6];
    logic [15:0] rd_word;
    logic        rd_oe;
    // reserved bits kept at their defaults
    pacr_row_t   rows [10] = '{'{3'h0, 16'h000f, 1'b1}, '{3'h0, 16'h0007, 1'b0},
        '{3'h0, 16'h0003, 1'b1}, '{3'h1, 16'h8008, 1'b0}, '{3'h2, 16'h701c, 1'b0},
        '{3'h3, 16'h7ace, 1'b0}, '{3'h4, 16'h0000, 1'b0}, '{3'h5, 16'hc812, 1'b1},
        '{3'h5, 16'h8806, 1'b0}, '{3'h5, 16'hc804, 1'b0}};

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    pacr_config_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk_link(sclk_link),
        .write_read_select(write_read_select), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe_n(sdio_oe_n), .tx_enable(tx_enable), .afe_ctrl(afe_ctrl));
    pacr_ctl_model ctl (.sclk_link(sclk_link), .write_read_select(write_read_select),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n));

    function automatic pacr_ctrl_t expect_ctrl(input logic tx, input logic run);
        pacr_ctrl_t c;
        logic signed [3:0] db [8] = '{4'sh3, 4'sh2, 4'sh1, 4'sh0, 4'shf, 4'she, 4'shd, 4'sha};
        c.rx_path_off = shadow[0][3] | (shadow[0][0] & tx);
        c.tx_path_off = shadow[0][3] | (shadow[0][1] & ~tx);
        c.dac_off = shadow[0][3] | (shadow[0][2] & ~tx);
        c.device_off = shadow[0][3];
        c.rx_lowpass_bypass = shadow[1][15];
        c.predriver_gain = shadow[2][4:2];
        c.gain_db = db[shadow[2][4:2]];
        c.process_tune_run = shadow[2][11] | run;
        c.line_driver_bypass = shadow[5][1];
        c.line_driver_high_current = &shadow[5][2:1];
        c.tx_lowpass_bypass = shadow[5][4];
        c.rx_highpass_enable = ~shadow[5][14];
        return c;
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // bank update and tx_enable sync both land well inside this
    task automatic settle();
        repeat (12) @(posedge ref_clk);
    endtask

    task automatic apply(input pacr_row_t r);
        ctl.send(r.addr, r.data, 1'b1);
        ctl.fetch(rd_word, rd_oe);
        shadow[r.addr] = r.data;
        @(posedge ref_clk) tx_enable <= r.tx;
        settle();
        check("readback", 32'(rd_word), 32'(r.data));
        check("oe_n released", 32'(sdio_oe_n), 32'h1);
        check("afe_ctrl", 32'(afe_ctrl), 32'(expect_ctrl(r.tx, 1'b0)));
    endtask

    // serial side needs several clock falls inside reset
    task automatic do_reset();
        @(posedge ref_clk) sys_rst <= 1'b1;
        repeat (4) ctl.tick();
        shadow = REG_DEFAULT;
        // transmit mode reads as receive while reset is held
        check("afe_ctrl in reset", 32'(afe_ctrl), 32'(expect_ctrl(1'b0, 1'b1)));
        @(posedge ref_clk) sys_rst <= 1'b0;
        repeat (3) ctl.tick();
        settle();
        check("afe_ctrl defaults", 32'(afe_ctrl), 32'(expect_ctrl(tx_enable, 1'b0)));
    endtask

    initial
    begin
        #200000;
        err_count++;
        stop_test();
    end

    initial
    begin
        sys_rst = 1'b1;
        tx_enable = 1'b0;
        err_count = 0;
        check_count = 0;
        #7;
        do_reset();
        $display("test reset done");
        foreach (rows[i])
            apply(rows[i]);
        $display("test table done");
        for (int g = 0; g < 8; g++)
            apply(pacr_row_t'{3'h2, 16'h7800 | 16'(g) << 2, 1'b0});
        $display("test gain codes done");
        ctl.send(3'h6, 16'h000f, 1'b1);
        ctl.fetch(rd_word, rd_oe);
        check("unmapped read oe", 32'(rd_oe), 32'h0);
        ctl.send(3'h0, 16'h000f, 1'b0);
        ctl.fetch(rd_word, rd_oe);
        settle();
        check("uncommitted read oe", 32'(rd_oe), 32'h0);
        check("afe_ctrl kept", 32'(afe_ctrl), 32'(expect_ctrl(tx_enable, 1'b0)));
        $display("test refusals done");
        apply(pacr_row_t'{3'h2, 16'h7010, 1'b1});
        do_reset();
        $display("test second reset done");
        stop_test();
    end
endmodule
`default_nettype wire
